/* inc/charger_consts.vh */
// Constants for the charger I2C register bank and interrupt pulse.
// Assumes inclusion by bare name.
`ifndef CHARGER_CONSTS_VH
`define CHARGER_CONSTS_VH

// Bus addressing and direction bit.
`define TARGET_ADDR         7'h6B
`define DIR_WRITE           1'h0
`define DIR_READ            1'h1

// Register offsets.
`define ADDR_STATUS         8'h00
`define ADDR_MASK           8'h02
`define ADDR_POWER_PATH     8'h03
`define ADDR_VTERM          8'h04
`define ADDR_ICHARGE        8'h05
`define ADDR_WATCHDOG       8'h06

// Reset values.
`define RST_STATUS          8'h00
`define RST_MASK            8'h00
`define RST_POWER_PATH      8'h00
`define RST_VTERM           8'h24
`define RST_ICHARGE         8'h44
`define RST_WATCHDOG        8'h43

// Bits that store a written value; the others read as zero.
`define WMASK_MASK          8'h7E
`define WMASK_POWER_PATH    8'h3F
`define WMASK_WATCHDOG      8'hDF

// Status register fields.
`define ST_TRICKLE          7
`define ST_FAST             6
`define ST_WDOG             5
`define ST_UV               4
`define ST_SHORT            3
`define ST_CHG_HI           2
`define ST_CHG_LO           1
`define ST_PGOOD            0

// Mask register fields.
`define M_UV                6
`define M_EOC               5
`define M_SHORT             4
`define M_STATE             3
`define M_PGOOD             2
`define M_TIMER             1

// Power path control fields.
`define PP_SCALE            5
`define PP_DLIM_HI          4
`define PP_DLIM_LO          3
`define PP_ILIM             2
`define PP_MODE_HI          1
`define PP_MODE_LO          0
`define MODE_POWER_DOWN     2'h1
`define CHG_END             2'h3

// Watchdog control fields.
`define WD_KICK             7
`define WD_EN               6

// Timing.
`define CLK_FREQ_MHZ        100
`define IRQ_PULSE_US        256
`define IRQ_PULSE_CYCLES    (`IRQ_PULSE_US * `CLK_FREQ_MHZ)
`define POWER_DOWN_S        8
`define POWER_DOWN_CYCLES   (`POWER_DOWN_S * 1000000 * `CLK_FREQ_MHZ)

`endif

/* src/bit_sync.v */
// Two-stage synchroniser for a bundle of independent level inputs.
// Assumes slow levels; bits are not coherent.
`timescale 1ns/1ps

module bit_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset.
    input  wire             i_clk,
    input  wire             i_reset,
    // Asynchronous levels in, synchronised levels out.
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    genvar g;

    // Each bit passes two flip-flops; the first is read only by the second.
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg stage1;
            reg stage2;
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    stage1 <= 1'h0;
                    stage2 <= 1'h0;
                end else begin
                    stage1 <= i_async[g];
                    stage2 <= stage1;
                end
            end
            assign o_sync[g] = stage2;
        end
    endgenerate

endmodule

/* src/charger_i2c_regs_irq.v */
// Holds the I2C target, the register bank and the interrupt events.
// Assumes external pull-ups on the open-drain lines
// and asynchronous charger status levels.
`timescale 1ns/1ps
`include "charger_consts.vh"

module charger_i2c_regs_irq #(
    parameter [31:0] IRQ_PULSE_CYCLES  = `IRQ_PULSE_CYCLES,
    parameter [31:0] POWER_DOWN_CYCLES = `POWER_DOWN_CYCLES
) (
    // Clock and reset.
    input  wire       i_clk,
    input  wire       i_reset,
    // I2C clock line.
    input  wire       i_scl,
    output wire       o_scl,
    output wire       o_scl_oe,
    // I2C data line.
    input  wire       i_sda,
    output wire       o_sda,
    output wire       o_sda_oe,
    // Open-drain interrupt line.
    output wire       o_interrupt_out_n,
    output wire       o_interrupt_oe,
    // Charger status levels.
    input  wire       i_trickle_timeout_flag,
    input  wire       i_fast_charge_timeout_flag,
    input  wire       i_watchdog_timeout_flag,
    input  wire       i_battery_undervoltage_flag,
    input  wire       i_sys_short_flag,
    input  wire [1:0] i_charge_state,
    input  wire       i_input_power_good,
    // Power path controls.
    output wire       o_charge_current_scale_up,
    output wire [1:0] o_discharge_current_limit,
    output wire       o_input_current_limit,
    output wire [1:0] o_battery_switch_mode,
    // Charge controls.
    output wire [7:0] o_charge_voltage_term_control,
    output wire [7:0] o_charge_current_control,
    // Watchdog controls.
    output wire [7:0] o_watchdog_timer_control,
    output wire       o_watchdog_enable,
    output wire       o_watchdog_kick
);

    // Bus state encodings.
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_WRITE = 3'h2;
    localparam [2:0] ST_ACK   = 3'h3;
    localparam [2:0] ST_READ  = 3'h4;
    localparam [2:0] ST_RACK  = 3'h5;

    wire [9:0] sync_in;
    wire [9:0] sync_out;
    wire       scl_s;
    wire       sda_s;
    wire [7:0] status_raw;
    reg        scl_d;
    reg        sda_d;
    wire       scl_rise;
    wire       scl_fall;
    wire       bus_start;
    wire       bus_stop;

    reg  [2:0] state;
    reg  [3:0] bit_cnt;
    reg  [7:0] shift;
    reg        dir;
    reg        ptr_phase;
    reg  [7:0] ptr;
    reg        sda_oe;
    reg        line_level;
    reg        wr_en;
    reg  [7:0] wr_addr;
    reg  [7:0] wr_data;
    wire [7:0] rd_data;

    reg  [7:0] charger_status;
    reg  [7:0] status_prev;
    reg  [7:0] interrupt_mask;
    reg  [7:0] power_path_control;
    reg  [7:0] charge_voltage_term_control;
    reg  [7:0] charge_current_control;
    reg  [7:0] watchdog_timer_control;
    reg        kick;
    reg [31:0] pd_count;
    wire       pd_running;
    wire       pd_done;

    wire       ev_timer;
    wire       ev_uv;
    wire       ev_short;
    wire       ev_state;
    wire       ev_eoc;
    wire       ev_pgood;
    wire       irq_trigger;
    wire       irq_active;

    // Register read decode; unmapped offsets read as zero.
    function [7:0] read_reg;
        input [7:0] addr;
        begin
            case (addr)
                `ADDR_STATUS:     read_reg = charger_status;
                `ADDR_MASK:       read_reg = interrupt_mask;
                `ADDR_POWER_PATH: read_reg = power_path_control;
                `ADDR_VTERM:      read_reg = charge_voltage_term_control;
                `ADDR_ICHARGE:    read_reg = charge_current_control;
                `ADDR_WATCHDOG:   read_reg = watchdog_timer_control;
                default:          read_reg = 8'h00;
            endcase
        end
    endfunction

    // Every pin-facing input passes the synchroniser first.
    assign sync_in = {i_scl, i_sda,
                      i_trickle_timeout_flag, i_fast_charge_timeout_flag,
                      i_watchdog_timeout_flag, i_battery_undervoltage_flag,
                      i_sys_short_flag, i_charge_state, i_input_power_good};

    bit_sync #(
        .WIDTH (10)
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (sync_in),
        .o_sync  (sync_out)
    );

    assign scl_s      = sync_out[9];
    assign sda_s      = sync_out[8];
    assign status_raw = sync_out[7:0];

    // Previous line levels; reset matches the synchroniser, so no false edge.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            scl_d <= 1'h0;
            sda_d <= 1'h0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Clock edges and bus conditions, seen in any state.
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    assign rd_data   = read_reg(ptr);

    // Bus target sequencer. The data line only moves after a falling
    // clock edge, so our own driving never looks like start or stop.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state     <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            dir       <= `DIR_WRITE;
            ptr_phase <= 1'h0;
            ptr       <= 8'h00;
            sda_oe    <= 1'h0;
            wr_en     <= 1'h0;
            wr_addr   <= 8'h00;
            wr_data   <= 8'h00;
        end else begin
            wr_en <= 1'h0;
            if (bus_start) begin
                state   <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'h0;
            end else if (bus_stop) begin
                state   <= ST_IDLE;
                sda_oe  <= 1'h0;
            end else begin
                case (state)
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            if (state == ST_ADDR) begin
                                if (shift[7:1] == `TARGET_ADDR) begin
                                    dir       <= shift[0];
                                    ptr_phase <= (shift[0] == `DIR_WRITE);
                                    sda_oe    <= 1'h1;
                                    state     <= ST_ACK;
                                end else begin
                                    state     <= ST_IDLE;
                                end
                            end else begin
                                sda_oe <= 1'h1;
                                state  <= ST_ACK;
                                if (ptr_phase) begin
                                    ptr       <= shift;
                                    ptr_phase <= 1'h0;
                                end else begin
                                    wr_en   <= 1'h1;
                                    wr_addr <= ptr;
                                    wr_data <= shift;
                                    ptr     <= ptr + 8'h01;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (dir == `DIR_READ) begin
                                shift  <= rd_data;
                                sda_oe <= ~rd_data[7];
                                ptr    <= ptr + 8'h01;
                                state  <= ST_READ;
                            end else begin
                                sda_oe <= 1'h0;
                                state  <= ST_WRITE;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            shift   <= {shift[6:0], 1'h0};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == 4'h7) begin
                                sda_oe <= 1'h0;
                                state  <= ST_RACK;
                            end else begin
                                sda_oe <= ~shift[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_s) begin
                                state <= ST_IDLE;
                            end else begin
                                state <= ST_ACK;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Constant low drive level for every open-drain pin.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            line_level <= 1'h0;
        end else begin
            line_level <= 1'h0;
        end
    end

    // Status follows the charger levels whatever the mask holds.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            charger_status <= `RST_STATUS;
            status_prev    <= `RST_STATUS;
        end else begin
            charger_status <= status_raw;
            status_prev    <= charger_status;
        end
    end

    // Power-down timer runs while the switch mode asks for it.
    assign pd_running = (power_path_control[`PP_MODE_HI:`PP_MODE_LO]
                         == `MODE_POWER_DOWN);
    assign pd_done    = pd_running
                        && (pd_count == POWER_DOWN_CYCLES - 32'h1);

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pd_count <= 32'h0;
        end else if (pd_running && !pd_done) begin
            pd_count <= pd_count + 32'h1;
        end else begin
            pd_count <= 32'h0;
        end
    end

    // Writable registers; a finished power-down restores the defaults.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            interrupt_mask              <= `RST_MASK;
            power_path_control          <= `RST_POWER_PATH;
            charge_voltage_term_control <= `RST_VTERM;
            charge_current_control      <= `RST_ICHARGE;
            watchdog_timer_control      <= `RST_WATCHDOG;
            kick                        <= 1'h0;
        end else if (pd_done) begin
            interrupt_mask              <= `RST_MASK;
            power_path_control          <= `RST_POWER_PATH;
            charge_voltage_term_control <= `RST_VTERM;
            charge_current_control      <= `RST_ICHARGE;
            watchdog_timer_control      <= `RST_WATCHDOG;
            kick                        <= 1'h0;
        end else begin
            kick <= 1'h0;
            if (wr_en) begin
                case (wr_addr)
                    `ADDR_MASK: begin
                        interrupt_mask <= wr_data & `WMASK_MASK;
                    end
                    `ADDR_POWER_PATH: begin
                        power_path_control <= wr_data & `WMASK_POWER_PATH;
                    end
                    `ADDR_VTERM: begin
                        charge_voltage_term_control <= wr_data;
                    end
                    `ADDR_ICHARGE: begin
                        charge_current_control <= wr_data;
                    end
                    `ADDR_WATCHDOG: begin
                        watchdog_timer_control <= wr_data & `WMASK_WATCHDOG;
                        kick <= wr_data[`WD_KICK];
                    end
                    default: begin
                        kick <= 1'h0;
                    end
                endcase
            end
        end
    end

    // Interrupt sources, each gated by its own mask bit.
    assign ev_timer = |(charger_status[`ST_TRICKLE:`ST_WDOG]
                        & ~status_prev[`ST_TRICKLE:`ST_WDOG])
                      & ~interrupt_mask[`M_TIMER];
    assign ev_uv    = charger_status[`ST_UV] & ~status_prev[`ST_UV]
                      & ~interrupt_mask[`M_UV];
    assign ev_short = charger_status[`ST_SHORT] & ~status_prev[`ST_SHORT]
                      & ~interrupt_mask[`M_SHORT];
    assign ev_state = (charger_status[`ST_CHG_HI:`ST_CHG_LO]
                       != status_prev[`ST_CHG_HI:`ST_CHG_LO])
                      & ~interrupt_mask[`M_STATE];
    assign ev_eoc   = (charger_status[`ST_CHG_HI:`ST_CHG_LO] == `CHG_END)
                      & (status_prev[`ST_CHG_HI:`ST_CHG_LO] != `CHG_END)
                      & ~interrupt_mask[`M_EOC];
    assign ev_pgood = (charger_status[`ST_PGOOD] ^ status_prev[`ST_PGOOD])
                      & ~interrupt_mask[`M_PGOOD];
    assign irq_trigger = ev_timer | ev_uv | ev_short
                         | ev_state | ev_eoc | ev_pgood;

    irq_pulse #(
        .PULSE_CYCLES (IRQ_PULSE_CYCLES)
    ) u_irq (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_trigger (irq_trigger),
        .o_active  (irq_active)
    );

    // Pin drive: every line is low when enabled, released otherwise.
    assign o_scl             = line_level;
    assign o_scl_oe          = line_level;
    assign o_sda             = line_level;
    assign o_sda_oe          = sda_oe;
    assign o_interrupt_out_n = line_level;
    assign o_interrupt_oe    = irq_active;

    // Control fields straight from their registers.
    assign o_charge_current_scale_up = power_path_control[`PP_SCALE];
    assign o_discharge_current_limit =
        power_path_control[`PP_DLIM_HI:`PP_DLIM_LO];
    assign o_input_current_limit     = power_path_control[`PP_ILIM];
    assign o_battery_switch_mode     =
        power_path_control[`PP_MODE_HI:`PP_MODE_LO];
    assign o_charge_voltage_term_control = charge_voltage_term_control;
    assign o_charge_current_control      = charge_current_control;
    assign o_watchdog_timer_control      = watchdog_timer_control;
    assign o_watchdog_enable = watchdog_timer_control[`WD_EN];
    assign o_watchdog_kick   = kick;

endmodule

/* src/irq_pulse.v */
// Fixed-width pulse timer for the interrupt line.
// Assumes the trigger is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`include "charger_consts.vh"

module irq_pulse #(
    parameter [31:0] PULSE_CYCLES = `IRQ_PULSE_CYCLES
) (
    // Clock and reset.
    input  wire i_clk,
    input  wire i_reset,
    // Event in, pulse out.
    input  wire i_trigger,
    output reg  o_active
);

    reg [31:0] count;

    // A trigger starts a pulse of exactly PULSE_CYCLES cycles.
    // Triggers while a pulse runs are merged into it.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count    <= 32'h0;
            o_active <= 1'h0;
        end else if (!o_active) begin
            count    <= 32'h0;
            o_active <= i_trigger;
        end else if (count == PULSE_CYCLES - 32'h1) begin
            count    <= 32'h0;
            o_active <= 1'h0;
        end else begin
            count    <= count + 32'h1;
        end
    end

endmodule

/* verif/charger_i2c_regs_irq_properties.sv */
// Checker for the charger target's lines, pulse and register outputs.
// Assumes binding into the top module.
`timescale 1ns/1ps

module charger_i2c_regs_irq_properties #(
    parameter [31:0] IRQ_PULSE_CYCLES  = 32'h14,
    parameter [31:0] POWER_DOWN_CYCLES = 32'h32
) (
    // Clock and reset.
    input wire       i_clk,
    input wire       i_reset,
    // Bus and interrupt lines.
    input wire       i_scl,
    input wire       o_scl,
    input wire       o_scl_oe,
    input wire       o_sda,
    input wire       o_sda_oe,
    input wire       o_interrupt_out_n,
    input wire       o_interrupt_oe,
    // Register outputs.
    input wire [1:0] o_battery_switch_mode,
    input wire [7:0] o_charge_voltage_term_control,
    input wire       o_watchdog_kick
);
    reg [31:0] pulse_cnt;
    reg [31:0] down_cnt;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Counts the cycles of a pulse and of a power-down period.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pulse_cnt <= 32'h0;
            down_cnt  <= 32'h0;
        end else begin
            pulse_cnt <= o_interrupt_oe ? pulse_cnt + 32'h1 : 32'h0;
            down_cnt  <= (o_battery_switch_mode == 2'h1) ?
                         down_cnt + 32'h1 : 32'h0;
        end
    end

    pull_low_only_a: assert property (
        !o_scl && !o_sda && !o_interrupt_out_n)
        else $error("line driven high");
    no_stretch_a: assert property (!o_scl_oe)
        else $error("clock line held low");
    sda_move_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data drive moved while clock high");
    pulse_max_a: assert property (pulse_cnt <= IRQ_PULSE_CYCLES)
        else $error("interrupt pulse too long");
    pulse_len_a: assert property ($fell(o_interrupt_oe) |->
        pulse_cnt == IRQ_PULSE_CYCLES) else $error("pulse width wrong");
    kick_single_a: assert property (
        o_watchdog_kick |=> !o_watchdog_kick)
        else $error("kick longer than one cycle");
    down_bound_a: assert property (
        down_cnt <= POWER_DOWN_CYCLES + 32'h2)
        else $error("power-down period overran");
    reg_move_low_a: assert property (
        $changed(o_charge_voltage_term_control)
        |-> !i_scl || $past(o_battery_switch_mode) == 2'h1)
        else $error("register moved while clock high");

    cover property ($fell(o_interrupt_oe));
    cover property (o_watchdog_kick);
    cover property ($rose(o_sda_oe));
endmodule

bind charger_i2c_regs_irq charger_i2c_regs_irq_properties #(
    .IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES),
    .POWER_DOWN_CYCLES(POWER_DOWN_CYCLES)
) chk_u (.*);

/* verif/charger_i2c_regs_irq_tb.sv */
// Self-checking bench for the charger target through its I2C pins.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`include "charger_consts.vh"

module charger_i2c_regs_irq_tb;
    localparam [31:0] PULSE = 32'h14;
    localparam [31:0] DOWN  = 32'h32;
    reg         i_clk = 1'h0;
    reg         i_reset = 1'h1;
    reg  [7:0]  st = 8'h00;
    reg  [31:0] seed = 32'h00016CCC;
    reg  [31:0] r;
    reg  [7:0]  bytes [0:7];
    reg  [7:0]  exp_q [$];
    reg  [8:0]  q;
    integer     mismatches = 0;
    integer     num_checks = 0;
    integer     i, n;
    wire        scl_pull, sda_pull, o_scl, o_scl_oe, o_sda, o_sda_oe;
    wire        irq_oe, scale, ilim, rx_valid, wden;
    wire [1:0]  dlim, mode;
    wire [7:0]  vterm, rx_data, icc, wdt;
    wire        scl = ~(scl_pull | (o_scl_oe & ~o_scl));
    wire        sda = ~(sda_pull | (o_sda_oe & ~o_sda));

    charger_i2c_regs_irq #(.IRQ_PULSE_CYCLES(PULSE),
        .POWER_DOWN_CYCLES(DOWN)) dut_u (
        .i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .o_scl(o_scl),
        .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda(o_sda),
        .o_sda_oe(o_sda_oe), .o_interrupt_out_n(), .o_interrupt_oe(irq_oe),
        .i_trickle_timeout_flag(st[7]), .i_fast_charge_timeout_flag(st[6]),
        .i_watchdog_timeout_flag(st[5]), .i_battery_undervoltage_flag(st[4]),
        .i_sys_short_flag(st[3]), .i_charge_state(st[2:1]),
        .i_input_power_good(st[0]), .o_charge_current_scale_up(scale),
        .o_discharge_current_limit(dlim), .o_input_current_limit(ilim),
        .o_battery_switch_mode(mode), .o_charge_voltage_term_control(vterm),
        .o_charge_current_control(icc), .o_watchdog_timer_control(wdt),
        .o_watchdog_enable(wden), .o_watchdog_kick());
    i2c_host_model host_u (.i_scl(scl), .i_sda(sda), .o_scl_pull(scl_pull),
        .o_sda_pull(sda_pull), .o_data(rx_data), .o_valid(rx_valid));

    // Free-running 100 MHz clock.
    always #5 i_clk = ~i_clk;

    // Compares each read byte with the oldest note.
    always @(posedge rx_valid)
        check("read", exp_q.pop_front(), rx_data);

    function automatic [31:0] xs();
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            xs = seed;
        end
    endfunction

    task check(input string name, input [7:0] e, input [7:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %s expected %h seen %h", name, e, g);
            end
        end
    endtask

    task wb(input [7:0] b, input [7:0] ack);
        begin
            host_u.xfer({b, 1'h1}, q);
            check("ack", ack, {7'h00, q[0]});
        end
    endtask

    task wr_regs(input [7:0] p, input integer cnt);
        begin
            host_u.start;
            wb({`TARGET_ADDR, `DIR_WRITE}, 8'h00);
            wb(p, 8'h00);
            for (i = 0; i < cnt; i = i + 1) wb(bytes[i], 8'h00);
            host_u.stop;
        end
    endtask

    task rd_regs(input [7:0] p, input integer cnt);
        begin
            host_u.start;
            wb({`TARGET_ADDR, `DIR_WRITE}, 8'h00);
            wb(p, 8'h00);
            host_u.start;
            wb({`TARGET_ADDR, `DIR_READ}, 8'h00);
            for (i = 0; i < cnt; i = i + 1) host_u.rbyte(i == cnt - 1);
            host_u.stop;
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask

    // Scenarios.
    initial begin
        repeat (2) @(negedge i_clk);
        i_reset = 1'h0;
        repeat (6) @(negedge i_clk);
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h24, 8'h44, 8'h43,
                  8'h00};
        rd_regs(8'h00, 8);
        $display("test defaults done");
        r = xs();
        host_u.start;
        wb({`TARGET_ADDR ^ (r[6:0] | 7'h01), `DIR_WRITE}, 8'h01);
        host_u.stop;
        $display("test foreign address done");
        for (n = 0; n < 7; n = n + 1) begin
            r = xs();
            bytes[n] = r[7:0];
        end
        bytes[3][1:0] = 2'h2;
        bytes[6][7] = 1'h1;
        wr_regs(8'h00, 7);
        check("mode", 8'h02, {6'h00, mode});
        check("path", {4'h0, bytes[3][5:2]},
              {4'h0, scale, dlim, ilim});
        check("icc", bytes[5], icc);
        check("wdt", bytes[6] & 8'hDF, wdt);
        check("wden", {7'h00, bytes[6][6]}, {7'h00, wden});
        exp_q = '{8'h00, 8'h00, bytes[2] & 8'h7E, bytes[3] & 8'h3F, bytes[4],
                  bytes[5], bytes[6] & 8'hDF};
        rd_regs(8'h00, 7);
        $display("test burst write done");
        bytes[0] = 8'h00;
        wr_regs(`ADDR_MASK, 1);
        @(negedge i_clk);
        st[0] = 1'h1;
        repeat (10) if (irq_oe !== 1'h1) @(negedge i_clk);
        n = 0;
        while (irq_oe === 1'h1 && n < 100) begin
            @(negedge i_clk);
            n = n + 1;
        end
        check("pulse", PULSE[7:0], n[7:0]);
        bytes[0] = 8'h7E;
        wr_regs(`ADDR_MASK, 1);
        r = xs();
        @(negedge i_clk);
        st = st ^ (r[7:0] | 8'h01);
        n = 0;
        repeat (30) begin
            @(negedge i_clk);
            if (irq_oe !== 1'h0) n = 1;
        end
        check("masked", 8'h00, n[7:0]);
        exp_q.push_back(st);
        rd_regs(`ADDR_STATUS, 1);
        $display("test interrupt done");
        bytes[0] = 8'h01;
        wr_regs(`ADDR_POWER_PATH, 1);
        repeat (DOWN + 10) @(negedge i_clk);
        check("restore", 8'h24, vterm);
        check("mode", 8'h00, {6'h00, mode});
        $display("test power-down done");
        wrap_up;
    end

    // Watchdog against a hang.
    initial begin
        #500000;
        mismatches = mismatches + 1;
        wrap_up;
    end
endmodule

/* verif/i2c_host_model.sv */
// Behavioural I2C controller standing for the host.
// Assumes the wires are resolved outside with pull-ups to high.
`timescale 1ns/1ps

module i2c_host_model (
    // Resolved wire levels.
    input  wire       i_scl,
    input  wire       i_sda,
    // Pull-low requests and read results.
    output reg        o_scl_pull = 1'h0,
    output reg        o_sda_pull = 1'h0,
    output reg  [7:0] o_data     = 8'h00,
    output reg        o_valid    = 1'h0
);
    // Start, or repeated start.
    task start;
        begin
            #20 o_sda_pull = 1'h0;
            #60 o_scl_pull = 1'h0;
            #80 o_sda_pull = 1'h1;
            #80 o_scl_pull = 1'h1;
        end
    endtask

    // Data rises while the clock is high.
    task stop;
        begin
            #20 o_sda_pull = 1'h1;
            #60 o_scl_pull = 1'h0;
            #80 o_sda_pull = 1'h0;
            #80;
        end
    endtask

    // Nine bit slots, MSB first; the last is the acknowledge slot.
    task xfer(input [8:0] d, output [8:0] q);
        integer i;
        begin
            for (i = 8; i >= 0; i = i - 1) begin
                #20 o_sda_pull = ~d[i];
                #60 o_scl_pull = 1'h0;
                while (!i_scl) #10;
                #80 q[i] = i_sda;
                o_scl_pull = 1'h1;
            end
        end
    endtask

    // Reads one byte and answers with acknowledge or not-acknowledge.
    task rbyte(input last);
        reg [8:0] q;
        begin
            xfer({8'hFF, last}, q);
            o_data = q[8:1];
            o_valid = 1'h1;
            #10 o_valid = 1'h0;
        end
    endtask
endmodule
